// ### include/adc_seq_pkg.sv
// Shared constants and types for the converter sequencer control block
package adc_seq_pkg;
    // Register byte addresses
    localparam logic [31:0] CMD_ADDR = 32'h400AC000;
    localparam logic [31:0] CFG_ADDR = 32'h400AC004;
    localparam logic [31:0] CHSET_ADDR = 32'h400AC010;
    localparam logic [31:0] CHCLR_ADDR = 32'h400AC014;
    localparam logic [31:0] CHSTATE_ADDR = 32'h400AC018;
    localparam logic [31:0] FLAGS_ADDR = 32'h400AC01C;
    localparam logic [31:0] LAST_ADDR = 32'h400AC020;
    localparam logic [31:0] RESULT_BASE = 32'h400AC030;
    localparam logic [31:0] RESULT_SPAN = 32'h00000020;
    localparam logic [31:0] RCNT_ADDR = 32'h400AC104;
    localparam logic [31:0] NRCNT_ADDR = 32'h400AC114;
    // Command bits
    localparam int CMD_SOFT_RESET_BIT = 0;
    localparam int CMD_START_BIT = 1;
    // Configuration fields
    localparam int CFG_HW_TRIG_BIT = 0;
    localparam int CFG_SOURCE_LSB = 1;
    localparam int CFG_LOW_RES_BIT = 4;
    localparam int CFG_SLEEP_BIT = 5;
    localparam int CFG_DIVIDER_LSB = 8;
    localparam int CFG_STARTUP_LSB = 16;
    localparam int CFG_HOLD_LSB = 24;
    localparam logic [31:0] CFG_RESET = 32'h00000000;
    localparam logic [31:0] CFG_WRITE_MASK = 32'h0F7F3F3F;
    localparam logic [10:0] STARTUP_UNIT = 11'h008;
    // Trigger source codes
    localparam logic [2:0] TRG_TIMER0 = 3'h0;
    localparam logic [2:0] TRG_TIMER1 = 3'h1;
    localparam logic [2:0] TRG_TIMER2 = 3'h2;
    localparam logic [2:0] TRG_PWM0 = 3'h3;
    localparam logic [2:0] TRG_PWM1 = 3'h4;
    localparam logic [2:0] TRG_EXTERNAL = 3'h6;
    // Status layout and reset state
    localparam logic [15:0] RCNT_RESET = 16'h0000;
    localparam logic END_OF_RECEIVE_RESET = 1'b1;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] HSIZE_WORD = 3'h2;
    localparam int RESULT_W = 10;

    typedef struct packed {
        logic [2:0] timer;
        logic [1:0] pwm_event;
        logic external;
    } trig_in_t;

    typedef struct packed {
        logic power;
        logic start;
        logic sample;
        logic [2:0] channel;
    } cell_ctrl_t;
endpackage

// ### hdl/adc_sequencer_control.sv
// Register file and conversion sequencer of the eight-channel converter
// Notes on behaviour
// RULE_01 - Command bit 0 written one resets the whole block like a hardware reset.
// RULE_02 - Command bit 1 written one starts a conversion sequence.
// RULE_03 - With hardware trigger disabled only software can start conversions.
// RULE_04 - With hardware trigger enabled the selected source starts conversions.
// RULE_05 - Source codes: timers 0-2, pwm events 0-1, code 6 external; 5,7 reserved.
// RULE_06 - Conversion clock is master clock over two times prescaler plus one.
// RULE_07 - Start-up wait is (field plus one) times eight conversion clocks.
// RULE_08 - Sample-and-hold lasts field value conversion clocks, field at bit 24.
// RULE_09 - Channel set register ones enable matching channels.
// RULE_10 - Channel clear register ones disable matching channels.
// RULE_11 - Channel state register shows one bit per enabled channel.
// RULE_12 - Software must not toggle a channel while its conversion runs.
// RULE_13 - End-of-conversion flag set only for enabled, finished channels.
// RULE_14 - Per-channel overrun flags in bits 15 to 8 since last status read.
// RULE_15 - Data-ready bit 16 set on new result until last result read.
// RULE_16 - General overrun bit 17 since last status read.
// RULE_17 - End-of-receive bit 18 set when counter hits zero, cleared by counter write.
// RULE_18 - Receive-buffer-full bit 19 is one when both counters are zero.
// RULE_19 - Low resolution gives 8-bit results, upper two bits zero.
// RULE_20 - Sleep mode powers up, waits start-up, converts, powers down, ignores triggers; the code drops triggers only outside idle, as in normal mode.
// RULE_21 - Channel result read clears its flag; last result read clears data-ready too.
// RULE_22 - Status read clears all overrun flags and general overrun.
// RULE_23 - Write-only registers read zero without side effects.
//
// The AHB-Lite register port was chosen for this implementation.
`timescale 1ns/1ns
module adc_sequencer_control #(
    parameter int NUM_CHANNELS = 8
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire adc_seq_pkg::trig_in_t trig_in,
    output adc_seq_pkg::cell_ctrl_t cell_ctrl,
    input wire logic cell_done,
    input wire logic [9:0] cell_data,
    output logic transfer_request,
    input wire logic transfer_ack
);
    initial begin
        if (NUM_CHANNELS < 1 || NUM_CHANNELS > 8) begin
            $error("NUM_CHANNELS must lie in 1..8");
        end
    end

    localparam logic [7:0] CH_MASK = 8'((9'h001 << NUM_CHANNELS) - 9'h001);

    typedef enum logic [1:0] {S_IDLE, S_STARTUP, S_SAMPLE, S_CONVERT} seq_state_t;

    function automatic logic [3:0] scan_from(input logic [7:0] mask, input logic [3:0] from);
        logic [3:0] hit;
        hit = 4'h0;
        for (int i = 0; i < 8; i++) begin
            if (mask[i] && (4'(i) >= from) && !hit[3]) begin
                hit = {1'b1, 3'(i)};
            end
        end
        return hit;
    endfunction

    function automatic logic trig_pick(input logic [2:0] code, input logic [5:0] lines);
        case (code)
            adc_seq_pkg::TRG_TIMER0: trig_pick = lines[0];
            adc_seq_pkg::TRG_TIMER1: trig_pick = lines[1];
            adc_seq_pkg::TRG_TIMER2: trig_pick = lines[2];
            adc_seq_pkg::TRG_PWM0: trig_pick = lines[3];
            adc_seq_pkg::TRG_PWM1: trig_pick = lines[4];
            adc_seq_pkg::TRG_EXTERNAL: trig_pick = lines[5];
            default: trig_pick = 1'b0;
        endcase
    endfunction

    logic soft_pulse_reg;
    logic rst;
    logic [31:0] cfg_reg;
    logic [7:0] ch_en_reg;
    logic [7:0] eoc_reg;
    logic [7:0] ovr_reg;
    logic data_ready_reg;
    logic general_overrun_reg;
    logic end_of_receive_reg;
    logic receive_buffer_full;
    logic [15:0] rcnt_reg;
    logic [15:0] nrcnt_reg;
    logic [9:0] result_mem [8];
    logic [9:0] last_result_reg;
    logic [2:0] last_ch_reg;
    logic wr_pend_reg;
    logic [31:0] wr_addr_reg;
    logic [31:0] hrdata_reg;
    logic [31:0] rdata_mux;
    logic [5:0] trig_s1_reg;
    logic [5:0] trig_s2_reg;
    logic [5:0] trig_s3_reg;
    seq_state_t state_reg;
    logic [2:0] cur_ch_reg;
    logic [10:0] phase_cnt_reg;
    logic power_reg;
    logic start_pulse_reg;
    logic [6:0] div_cnt_reg;
    logic transfer_request_reg;

    // Configuration fields
    logic hw_trig_en;
    logic [2:0] trig_source;
    logic low_resolution;
    logic sleep_mode;
    logic [5:0] clock_divider;
    logic [6:0] startup;
    logic [3:0] sample_hold;
    assign hw_trig_en = cfg_reg[adc_seq_pkg::CFG_HW_TRIG_BIT];
    assign trig_source = cfg_reg[adc_seq_pkg::CFG_SOURCE_LSB +: 3];
    assign low_resolution = cfg_reg[adc_seq_pkg::CFG_LOW_RES_BIT];
    assign sleep_mode = cfg_reg[adc_seq_pkg::CFG_SLEEP_BIT];
    assign clock_divider = cfg_reg[adc_seq_pkg::CFG_DIVIDER_LSB +: 6];
    assign startup = cfg_reg[adc_seq_pkg::CFG_STARTUP_LSB +: 7];
    assign sample_hold = cfg_reg[adc_seq_pkg::CFG_HOLD_LSB +: 4];

    // Soft reset acts on the cycle after the write, like a reset pulse
    assign rst = !reset_n || soft_pulse_reg; // RULE_01

    // Bus slave: reads sample at the address phase, writes commit in the data phase
    logic addr_take;
    logic rd_take;
    logic wr_take;
    logic wr_commit;
    logic [31:0] res_off;
    logic res_rd_hit;
    logic [2:0] res_idx;
    assign addr_take = hsel && hready && (htrans == adc_seq_pkg::HTRANS_NONSEQ)
        && (hsize == adc_seq_pkg::HSIZE_WORD);
    // Stall a read behind a pending write so it sees the written value
    assign hreadyout = !(wr_pend_reg && hsel && (htrans == adc_seq_pkg::HTRANS_NONSEQ) && !hwrite);
    assign hresp = 1'b0;
    assign rd_take = addr_take && !hwrite;
    assign wr_take = addr_take && hwrite;
    assign wr_commit = wr_pend_reg;
    assign res_off = haddr - adc_seq_pkg::RESULT_BASE;
    assign res_idx = res_off[4:2];
    assign res_rd_hit = (res_off < adc_seq_pkg::RESULT_SPAN) && (res_off[1:0] == 2'h0)
        && CH_MASK[res_idx];

    logic wr_cmd;
    logic sw_start;
    logic rd_flags;
    logic rd_last;
    logic [7:0] rd_res_clr;
    assign wr_cmd = wr_commit && (wr_addr_reg == adc_seq_pkg::CMD_ADDR);
    assign sw_start = wr_cmd && hwdata[adc_seq_pkg::CMD_START_BIT]; // RULE_02
    assign rd_flags = rd_take && (haddr == adc_seq_pkg::FLAGS_ADDR);
    assign rd_last = rd_take && (haddr == adc_seq_pkg::LAST_ADDR);
    assign rd_res_clr = (rd_take && res_rd_hit) ? (8'h01 << res_idx) : 8'h00; // RULE_21
    assign receive_buffer_full = (rcnt_reg == 16'h0000) && (nrcnt_reg == 16'h0000); // RULE_18

    always_comb begin
        rdata_mux = 32'h00000000; // RULE_23
        if (res_rd_hit) begin
            rdata_mux = {22'h000000, result_mem[res_idx]};
        end else begin
            case (haddr)
                adc_seq_pkg::CFG_ADDR: rdata_mux = cfg_reg;
                adc_seq_pkg::CHSTATE_ADDR: rdata_mux = {24'h000000, ch_en_reg}; // RULE_11
                adc_seq_pkg::FLAGS_ADDR: rdata_mux = {12'h000, receive_buffer_full, end_of_receive_reg,
                    general_overrun_reg, data_ready_reg,
                    ovr_reg, eoc_reg};
                adc_seq_pkg::LAST_ADDR: rdata_mux = {22'h000000, last_result_reg};
                adc_seq_pkg::RCNT_ADDR: rdata_mux = {16'h0000, rcnt_reg};
                adc_seq_pkg::NRCNT_ADDR: rdata_mux = {16'h0000, nrcnt_reg};
                default: rdata_mux = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            soft_pulse_reg <= 1'b0;
        end else begin
            soft_pulse_reg <= wr_cmd && hwdata[adc_seq_pkg::CMD_SOFT_RESET_BIT]; // RULE_01
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 32'h00000000;
            hrdata_reg <= 32'h00000000;
        end else begin
            wr_pend_reg <= wr_take;
            if (wr_take) begin
                wr_addr_reg <= haddr;
            end
            if (rd_take) begin
                hrdata_reg <= rdata_mux;
            end
        end
    end
    assign hrdata = hrdata_reg;

    // Configuration and channel enables
    always_ff @(posedge clock) begin
        if (rst) begin
            cfg_reg <= adc_seq_pkg::CFG_RESET;
            ch_en_reg <= 8'h00;
        end else if (wr_commit) begin
            if (wr_addr_reg == adc_seq_pkg::CFG_ADDR) begin
                cfg_reg <= hwdata & adc_seq_pkg::CFG_WRITE_MASK;
            end
            if (wr_addr_reg == adc_seq_pkg::CHSET_ADDR) begin
                ch_en_reg <= ch_en_reg | (hwdata[7:0] & CH_MASK); // RULE_09
            end
            if (wr_addr_reg == adc_seq_pkg::CHCLR_ADDR) begin
                ch_en_reg <= ch_en_reg & ~hwdata[7:0]; // RULE_10
            end
        end
    end

    // Trigger pins cross into the master clock domain
    always_ff @(posedge clock) begin
        if (rst) begin
            trig_s1_reg <= 6'h00;
            trig_s2_reg <= 6'h00;
            trig_s3_reg <= 6'h00;
        end else begin
            trig_s1_reg <= {trig_in.external, trig_in.pwm_event, trig_in.timer};
            trig_s2_reg <= trig_s1_reg;
            trig_s3_reg <= trig_s2_reg;
        end
    end

    logic hw_start;
    logic start_req;
    assign hw_start = hw_trig_en && trig_pick(trig_source, trig_s2_reg & ~trig_s3_reg); // RULE_03 RULE_04 RULE_05
    assign start_req = sw_start || hw_start;

    // Conversion clock divider, restarted at each sequence for exact counts
    logic [6:0] div_limit;
    logic tick;
    assign div_limit = {clock_divider, 1'b1};
    assign tick = (div_cnt_reg == div_limit); // RULE_06
    always_ff @(posedge clock) begin
        if (rst || state_reg == S_IDLE || tick) begin
            div_cnt_reg <= 7'h00;
        end else begin
            div_cnt_reg <= div_cnt_reg + 7'h01;
        end
    end

    logic [10:0] startup_target;
    logic [3:0] first_hit;
    logic [3:0] next_hit;
    logic conv_done;
    assign startup_target = ({4'h0, startup} + 11'h001) * adc_seq_pkg::STARTUP_UNIT;
    assign first_hit = scan_from(ch_en_reg & CH_MASK, 4'h0);
    assign next_hit = scan_from(ch_en_reg & CH_MASK, {1'b0, cur_ch_reg} + 4'h1);
    assign conv_done = (state_reg == S_CONVERT) && cell_done;

    // Sequencer; start requests outside idle are dropped
    always_ff @(posedge clock) begin
        if (rst) begin
            state_reg <= S_IDLE;
            cur_ch_reg <= 3'h0;
            phase_cnt_reg <= 11'h000;
            power_reg <= 1'b0;
            start_pulse_reg <= 1'b0;
        end else begin
            start_pulse_reg <= 1'b0;
            case (state_reg)
                S_IDLE: begin
                    if (start_req && first_hit[3]) begin
                        cur_ch_reg <= first_hit[2:0];
                        phase_cnt_reg <= 11'h000;
                        power_reg <= 1'b1;
                        state_reg <= power_reg ? S_SAMPLE : S_STARTUP; // RULE_20
                    end
                end
                S_STARTUP: begin
                    if (tick) begin
                        if (phase_cnt_reg + 11'h001 == startup_target) begin // RULE_07
                            phase_cnt_reg <= 11'h000;
                            state_reg <= S_SAMPLE;
                        end else begin
                            phase_cnt_reg <= phase_cnt_reg + 11'h001;
                        end
                    end
                end
                S_SAMPLE: begin
                    if (sample_hold == 4'h0 || (tick && phase_cnt_reg + 11'h001 == {7'h00, sample_hold})) begin // RULE_08
                        phase_cnt_reg <= 11'h000;
                        start_pulse_reg <= 1'b1;
                        state_reg <= S_CONVERT;
                    end else if (tick) begin
                        phase_cnt_reg <= phase_cnt_reg + 11'h001;
                    end
                end
                S_CONVERT: begin
                    if (cell_done) begin
                        if (next_hit[3]) begin
                            cur_ch_reg <= next_hit[2:0];
                            state_reg <= S_SAMPLE;
                        end else begin
                            state_reg <= S_IDLE;
                            if (sleep_mode) begin
                                power_reg <= 1'b0; // RULE_20
                            end
                        end
                    end
                end
                default: state_reg <= S_IDLE;
            endcase
        end
    end

    assign cell_ctrl.power = power_reg;
    assign cell_ctrl.start = start_pulse_reg;
    assign cell_ctrl.sample = (state_reg == S_SAMPLE);
    assign cell_ctrl.channel = cur_ch_reg;

    // Results; a low-resolution result keeps its top two bits clear
    logic [9:0] result_in;
    assign result_in = low_resolution ? {2'h0, cell_data[7:0]} : cell_data; // RULE_19
    always_ff @(posedge clock) begin
        if (rst) begin
            last_result_reg <= 10'h000;
            last_ch_reg <= 3'h0;
            for (int i = 0; i < 8; i++) begin
                result_mem[i] <= 10'h000;
            end
        end else if (conv_done) begin
            last_result_reg <= result_in;
            last_ch_reg <= cur_ch_reg;
            if (ch_en_reg[cur_ch_reg]) begin
                result_mem[cur_ch_reg] <= result_in;
            end
        end
    end

    // Flags: a hardware set in the clearing cycle wins
    logic [7:0] eoc_set;
    logic [7:0] eoc_clr;
    assign eoc_set = (conv_done && ch_en_reg[cur_ch_reg]) ? (8'h01 << cur_ch_reg) : 8'h00; // RULE_13
    assign eoc_clr = rd_res_clr | (rd_last ? (8'h01 << last_ch_reg) : 8'h00); // RULE_21
    always_ff @(posedge clock) begin
        if (rst) begin
            eoc_reg <= 8'h00;
            ovr_reg <= 8'h00;
            data_ready_reg <= 1'b0;
            general_overrun_reg <= 1'b0;
            transfer_request_reg <= 1'b0;
        end else begin
            eoc_reg <= (eoc_reg & ~eoc_clr) | eoc_set;
            ovr_reg <= (rd_flags ? 8'h00 : ovr_reg) | (eoc_set & eoc_reg); // RULE_14 RULE_22
            data_ready_reg <= (data_ready_reg && !rd_last) || conv_done; // RULE_15
            general_overrun_reg <= (general_overrun_reg && !rd_flags) || (conv_done && data_ready_reg); // RULE_16 RULE_22
            transfer_request_reg <= conv_done && !data_ready_reg;
        end
    end
    assign transfer_request = transfer_request_reg;

    // Receive counters of the transfer channel
    logic wr_rcnt;
    logic wr_nrcnt;
    logic rcnt_hits_zero;
    assign wr_rcnt = wr_commit && (wr_addr_reg == adc_seq_pkg::RCNT_ADDR);
    assign wr_nrcnt = wr_commit && (wr_addr_reg == adc_seq_pkg::NRCNT_ADDR);
    assign rcnt_hits_zero = transfer_ack && (rcnt_reg == 16'h0001) && !wr_rcnt;
    always_ff @(posedge clock) begin
        if (rst) begin
            rcnt_reg <= adc_seq_pkg::RCNT_RESET;
            nrcnt_reg <= adc_seq_pkg::RCNT_RESET;
            end_of_receive_reg <= adc_seq_pkg::END_OF_RECEIVE_RESET;
        end else begin
            if (wr_rcnt) begin
                rcnt_reg <= hwdata[15:0];
            end else if (rcnt_hits_zero) begin
                rcnt_reg <= nrcnt_reg;
            end else if (transfer_ack && rcnt_reg != 16'h0000) begin
                rcnt_reg <= rcnt_reg - 16'h0001;
            end
            if (wr_nrcnt) begin
                nrcnt_reg <= hwdata[15:0];
            end else if (rcnt_hits_zero) begin
                nrcnt_reg <= 16'h0000;
            end
            end_of_receive_reg <= (end_of_receive_reg && !(wr_rcnt || wr_nrcnt)) || rcnt_hits_zero; // RULE_17
        end
    end

    // Checks
    a_soft_reset_effect: assert property (@(posedge clock) disable iff (!reset_n) // RULE_01
        soft_pulse_reg |-> ##1 (cfg_reg == 32'h0 && ch_en_reg == 8'h0 && state_reg == S_IDLE))
        else $error("soft reset did not clear block");
    a_start_leaves_idle: assert property (@(posedge clock) disable iff (rst) // RULE_02
        (state_reg == S_IDLE && sw_start && |(ch_en_reg & CH_MASK)) |=> state_reg != S_IDLE)
        else $error("software start ignored");
    a_hw_trigger_gate: assert property (@(posedge clock) disable iff (rst) // RULE_03
        (state_reg == S_IDLE && !sw_start && !hw_trig_en) |=> state_reg == S_IDLE)
        else $error("sequence began without start");
    a_trigger_source: assert property (@(posedge clock) disable iff (rst) // RULE_05
        hw_start |-> (hw_trig_en && trig_source != 3'h5 && trig_source != 3'h7))
        else $error("reserved or idle trigger source fired");
    a_tick_period: assert property (@(posedge clock) disable iff (rst) // RULE_06
        (tick && $stable(clock_divider)) |=> (!tick && div_cnt_reg == 7'h00))
        else $error("conversion clock period wrong");
    a_startup_exit: assert property (@(posedge clock) disable iff (rst) // RULE_07
        (state_reg == S_STARTUP && phase_cnt_reg + 11'h001 < startup_target) |=> state_reg != S_SAMPLE)
        else $error("start-up ended early");
    a_sample_to_conv: assert property (@(posedge clock) disable iff (rst) // RULE_08
        start_pulse_reg |-> (state_reg == S_CONVERT && $past(state_reg) == S_SAMPLE))
        else $error("conversion started outside sample phase");
    a_channel_set: assert property (@(posedge clock) disable iff (rst) // RULE_09
        (wr_commit && wr_addr_reg == adc_seq_pkg::CHSET_ADDR) |=> ((ch_en_reg & $past(hwdata[7:0] & CH_MASK))
        == $past(hwdata[7:0] & CH_MASK)))
        else $error("channel not enabled");
    a_channel_clear: assert property (@(posedge clock) disable iff (rst) // RULE_10
        (wr_commit && wr_addr_reg == adc_seq_pkg::CHCLR_ADDR) |=> ((ch_en_reg & $past(hwdata[7:0])) == 8'h00))
        else $error("channel not disabled");
    a_eoc_after_done: assert property (@(posedge clock) disable iff (rst) // RULE_13
        (conv_done && ch_en_reg[cur_ch_reg]) |=> eoc_reg[$past(cur_ch_reg)])
        else $error("end of conversion not flagged");
    a_buffer_full_zero: assert property (@(posedge clock) disable iff (rst) // RULE_18
        (wr_rcnt && hwdata[15:0] != 16'h0000) |=> !receive_buffer_full)
        else $error("buffer full flag wrong");
    a_status_read_clear: assert property (@(posedge clock) disable iff (rst) // RULE_22
        (rd_flags && !conv_done) |=> (ovr_reg == 8'h00 && !general_overrun_reg))
        else $error("overrun flags survived status read");
    a_low_res_top_zero: assert property (@(posedge clock) disable iff (rst) // RULE_19
        (conv_done && low_resolution) |=> last_result_reg[9:8] == 2'h0)
        else $error("low resolution top bits set");
    a_sleep_power_down: assert property (@(posedge clock) disable iff (rst) // RULE_20
        (conv_done && !next_hit[3] && sleep_mode) |=> (!power_reg && state_reg == S_IDLE))
        else $error("cell left powered in sleep mode");

    c_full_sequence: cover property (@(posedge clock) disable iff (rst)
        state_reg == S_STARTUP ##[1:1000] conv_done);
    c_overrun: cover property (@(posedge clock) disable iff (rst) |ovr_reg);
    c_hw_start: cover property (@(posedge clock) disable iff (rst) hw_start && state_reg == S_IDLE);
    c_end_rx: cover property (@(posedge clock) disable iff (rst) rcnt_hits_zero);
endmodule // adc_sequencer_control

// ### sim/cell_model.sv
// Behavioural analog cell answering each start pulse with one result
`timescale 1ns/1ns
module cell_model #(
    parameter int DELAY = 4,
    parameter logic [9:0] RESULT = 10'h2A5
) (
    input wire logic clock,
    input wire adc_seq_pkg::cell_ctrl_t cell_ctrl,
    output logic cell_done,
    output logic [9:0] cell_data
);
    int wait_reg = 0;
    initial cell_done = 1'b0;
    initial cell_data = 10'h000;
    always @(posedge clock) begin
        cell_done <= 1'b0;
        // Data toggles outside the done cycle so a stale sample cannot match
        cell_data <= ~cell_data;
        if (cell_ctrl.start) begin
            wait_reg <= DELAY;
        end else if (wait_reg != 0) begin
            wait_reg <= wait_reg - 1;
        end
        if (wait_reg == 1) begin
            cell_done <= 1'b1;
            cell_data <= RESULT;
        end
    end
endmodule // cell_model

// ### sim/tb_top.sv
// Self-checking bench for the converter sequencer control
`timescale 1ns/1ns
module tb_top;
    localparam logic [9:0] RES = 10'h2A5;
    logic clock = 1'b0;
    logic reset_n = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic hready, hreadyout, hresp, cell_done, transfer_request;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = adc_seq_pkg::HSIZE_WORD;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, r, cfg;
    logic [31:0] seed = 32'h74F0E728;
    logic [9:0] cell_data;
    adc_seq_pkg::trig_in_t trig_in = '0;
    adc_seq_pkg::cell_ctrl_t cell_ctrl;
    logic transfer_ack = 1'b0;
    int failures = 0, checked = 0, cycles = 0, requests = 0;
    assign hready = hreadyout;
    always #25 clock = ~clock;
    adc_sequencer_control uut(.clock(clock), .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .trig_in(trig_in), .cell_ctrl(cell_ctrl), .cell_done(cell_done), .cell_data(cell_data),
        .transfer_request(transfer_request), .transfer_ack(transfer_ack));
    cell_model #(.RESULT(RES)) partner(.clock(clock), .cell_ctrl(cell_ctrl), .cell_done(cell_done),
        .cell_data(cell_data));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [31:0] last_exp(input logic [31:0] c);
        return c[adc_seq_pkg::CFG_LOW_RES_BIT] ? {24'h0, RES[7:0]} : {22'h0, RES};
    endfunction
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        checked++;
        if (s !== e) begin
            failures++;
            $display("unexpected %s expected %h seen %h", n, e, s);
        end
    endtask
    // Entered and left just after a rising edge; ready judged where settled
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        haddr <= a;
        hwrite <= w;
        htrans <= adc_seq_pkg::HTRANS_NONSEQ;
        do @(negedge clock); while (hreadyout !== 1'b1);
        @(posedge clock);
        htrans <= 2'h0;
        hwdata <= d;
        do @(negedge clock); while (hreadyout !== 1'b1);
        r = hrdata;
        @(posedge clock);
    endtask
    // A hardware start holds the external trigger line high until the result
    task automatic convert(input logic hw);
        int i;
        if (hw) trig_in.external <= 1'b1;
        else bus(1'b1, adc_seq_pkg::CMD_ADDR, 32'h00000002);
        for (i = 0; i < 3000 && cell_done !== 1'b1; i++) @(negedge clock);
        @(posedge clock);
        trig_in.external <= 1'b0;
        @(posedge clock);
    endtask
    always @(posedge clock) if (transfer_request === 1'b1) requests <= requests + 1;
    task automatic complete_run;
        if (failures == 0 && checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            failures++;
            complete_run();
        end
    end
    initial begin
        repeat (16) @(posedge clock);
        reset_n <= 1'b1;
        hsel <= 1'b1;
        @(posedge clock);
        bus(1'b0, adc_seq_pkg::FLAGS_ADDR, 32'h0);
        chk("flags", r, 32'h000C0000);
        bus(1'b1, adc_seq_pkg::CHSET_ADDR, 32'h00000005);
        bus(1'b1, adc_seq_pkg::CHCLR_ADDR, 32'h00000001);
        bus(1'b0, adc_seq_pkg::CHSTATE_ADDR, 32'h0);
        chk("chstate", r, 32'h00000004);
        // Short prescaler and start-up keep each sequence brief
        cfg = lfsr(seed) & 32'h0F03033E;
        bus(1'b1, adc_seq_pkg::CFG_ADDR, cfg);
        bus(1'b0, adc_seq_pkg::CFG_ADDR, 32'h0);
        chk("cfg", r, cfg);
        bus(1'b0, adc_seq_pkg::CMD_ADDR, 32'h0);
        chk("cmd", r, 32'h0);
        chk("hresp", 32'(hresp), 32'h0);
        convert(1'b0);
        bus(1'b0, adc_seq_pkg::FLAGS_ADDR, 32'h0);
        chk("flags", r, 32'h000D0004);
        convert(1'b0);
        bus(1'b0, adc_seq_pkg::FLAGS_ADDR, 32'h0);
        chk("flags", r, 32'h000F0404);
        bus(1'b0, adc_seq_pkg::FLAGS_ADDR, 32'h0);
        chk("flags", r, 32'h000D0004);
        bus(1'b0, adc_seq_pkg::LAST_ADDR, 32'h0);
        chk("last", r, last_exp(cfg));
        bus(1'b0, adc_seq_pkg::FLAGS_ADDR, 32'h0);
        chk("flags", r, 32'h000C0000);
        // External trigger in sleep mode
        bus(1'b1, adc_seq_pkg::CFG_ADDR, cfg | 32'h0000002D);
        convert(1'b1);
        chk("power", 32'(cell_ctrl.power), 32'h0);
        bus(1'b0, adc_seq_pkg::FLAGS_ADDR, 32'h0);
        chk("flags", r, 32'h000D0004);
        bus(1'b1, adc_seq_pkg::RCNT_ADDR, 32'h00000002);
        bus(1'b0, adc_seq_pkg::FLAGS_ADDR, 32'h0);
        chk("flags", r, 32'h00010004);
        repeat (2) begin
            transfer_ack <= 1'b1;
            @(posedge clock);
            transfer_ack <= 1'b0;
            @(posedge clock);
        end
        bus(1'b0, adc_seq_pkg::FLAGS_ADDR, 32'h0);
        chk("flags", r, 32'h000D0004);
        chk("requests", requests, 32'h2);
        bus(1'b1, adc_seq_pkg::CMD_ADDR, 32'h00000001);
        repeat (2) @(posedge clock);
        bus(1'b0, adc_seq_pkg::CHSTATE_ADDR, 32'h0);
        chk("chstate", r, 32'h0);
        bus(1'b0, adc_seq_pkg::CFG_ADDR, 32'h0);
        chk("cfg", r, 32'h0);
        complete_run();
    end
endmodule // tb_top
